// *** design/dcd_pkg.sv ***
// Constants shared by the diagnostic command engine and its stores
package dcd_pkg;
   // Storage geometry
   localparam logic [15:0] SBUF_WORDS = 16'h0100;
   localparam int SBUF_AW = 9;
   localparam int TBUF_AW = 15;
   localparam int FMT_REGS = 7;
   localparam int HDR_BYTES = 6;
   localparam logic [15:0] HDR_WORDS = 16'h0006;
   localparam logic [15:0] FMT_WORDS = 16'h0007;
   // Register offsets on the host port
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_SECT = 8'h08;
   localparam logic [7:0] REG_CYL = 8'h0C;
   localparam logic [7:0] REG_DSIZE = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;
   // Command word fields
   localparam int CMD_TOGGLE_BIT = 12;
   localparam int CMD_ANY_BIT = 13;
   localparam int CMD_TRACK_BIT = 14;
   localparam int CMD_DIR_BIT = 15;
   localparam logic [2:0] OP_WBUF = 3'h1;
   localparam logic [2:0] OP_RBUF = 3'h2;
   localparam logic [2:0] OP_RHDR = 3'h3;
   localparam logic [2:0] OP_RPHYS = 3'h4;
   localparam logic [2:0] OP_REGS = 3'h5;
   // Status word bits
   localparam int STAT_BUSY = 0;
   localparam int STAT_CUR = 1;
   localparam int STAT_DONE = 2;
   localparam int STAT_ERR = 3;
   // Reset values and counts
   localparam logic [15:0] DSIZE_RST = 16'h0100;
   localparam logic [1:0] TRK_HDR_LAST = 2'h2;
   localparam logic [2:0] HDR_LAST = 3'h5;
   // Header byte positions
   localparam int HDR_CYL_HI = 0;
   localparam int HDR_CYL_LO = 1;
   localparam int HDR_HEAD = 2;
endpackage

// *** design/dcd_mem_if.sv ***
// Word store access bundle between the engine and its stores
`timescale 1ns/1ns
`default_nettype none
interface dcd_mem_if #(parameter int AW = 9) ();
   logic we;
   logic [AW-1:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport ctrl(output we, output addr, output wdata, input rdata);
   modport mem(input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** design/dcd_sector_bufs.sv ***
// Two formatter sector buffers of 256 words, picked by address msb
`timescale 1ns/1ns
`default_nettype none
module dcd_sector_bufs
   import dcd_pkg::*;
(
   input wire logic clock_i,
   input wire logic ce_i,
   dcd_mem_if.mem port
);
   logic [15:0] mem [0:(1<<SBUF_AW)-1];

   // Write port, frozen with the clock enable
   always_ff @(posedge clock_i) begin
      if (ce_i && port.we) begin
         mem[port.addr] <= port.wdata;
      end
   end

   // Read is combinational so the engine saves a cycle per word
   assign port.rdata = mem[port.addr];
endmodule
`default_nettype wire

// *** design/dcd_track_buf.sv ***
// Track buffer of 32768 words (128 blocks of 256), word addressed
`timescale 1ns/1ns
`default_nettype none
module dcd_track_buf
   import dcd_pkg::*;
(
   input wire logic clock_i,
   input wire logic ce_i,
   dcd_mem_if.mem port
);
   logic [15:0] mem [0:(1<<TBUF_AW)-1];

   // Write port, frozen with the clock enable
   always_ff @(posedge clock_i) begin
      if (ce_i && port.we) begin
         mem[port.addr] <= port.wdata;
      end
   end

   // Flip-flop storage, so an async read costs nothing extra
   assign port.rdata = mem[port.addr];
endmodule
`default_nettype wire

// *** design/dcd_diag_engine.sv ***
// Diagnostic command engine: buffers, headers, sectors, register set
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module dcd_diag_engine
   import dcd_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rd_data_o,
   output logic mem_req_o,
   output logic mem_wr_o,
   output logic [15:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   input wire logic [15:0] mem_rdata_i,
   input wire logic mem_ack_i,
   input wire logic disk_index_i,
   input wire logic disk_valid_i,
   input wire logic disk_hdr_i,
   input wire logic [15:0] disk_word_i
);
   typedef enum logic [3:0] {
      S_IDLE, S_IN_REQ, S_IN_WAIT, S_OUT_FETCH, S_OUT_REQ,
      S_OUT_WAIT, S_TRK, S_SEARCH, S_CAP, S_FIN
   } dcd_state_t;

   typedef struct packed {
      dcd_state_t st;
      logic [2:0] op;
      logic tgl;
      logic any;
      logic trk;
      logic dir;
      logic [15:0] maddr;
      logic [15:0] sect;
      logic [15:0] cyl;
      logic [15:0] dsize;
      logic [15:0] idx;
      logic [15:0] cnt;
      logic cur;
      logic done;
      logic err;
      logic [1:0] trkn;
      logic sync;
      logic [2:0] hb;
      logic [7:0] phys;
      logic seen_idx;
      logic [HDR_BYTES-1:0][7:0] hlive;
      logic [HDR_BYTES-1:0][7:0] hdr;
      logic [FMT_REGS-1:0][15:0] fmt;
      logic [15:0] rdat;
      logic mreq;
      logic mwr;
      logic [15:0] maddr_o;
      logic [15:0] mwdata;
      logic sb_we;
      logic [SBUF_AW-1:0] sb_addr;
      logic [15:0] sb_wd;
      logic tbuf_we;
      logic [TBUF_AW-1:0] tbuf_addr;
      logic [15:0] tbuf_wd;
   } dcd_regs_t;

   dcd_regs_t s_reg;
   dcd_regs_t s_next;
   logic hstart;
   logic hend;
   logic psel;
   logic trk_ok;
   logic [HDR_BYTES-1:0][7:0] hcur;
   logic [15:0] clamp;

   dcd_mem_if #(.AW(SBUF_AW)) sb_if ();
   dcd_mem_if #(.AW(TBUF_AW)) tbuf_if ();

   // Sector buffers and track buffer stores
   dcd_sector_bufs u_sbuf (
      .clock_i(clock_i),
      .ce_i(ce_i),
      .port(sb_if)
   );
   dcd_track_buf u_tbuf (
      .clock_i(clock_i),
      .ce_i(ce_i),
      .port(tbuf_if)
   );

   // Store ports come straight from the state record
   assign sb_if.we = s_reg.sb_we;
   assign sb_if.addr = s_reg.sb_addr;
   assign sb_if.wdata = s_reg.sb_wd;
   assign tbuf_if.we = s_reg.tbuf_we;
   assign tbuf_if.addr = s_reg.tbuf_addr;
   assign tbuf_if.wdata = s_reg.tbuf_wd;

   // Outputs are all flops of the state record
   assign rd_data_o = s_reg.rdat;
   assign mem_req_o = s_reg.mreq;
   assign mem_wr_o = s_reg.mwr;
   assign mem_addr_o = s_reg.maddr_o;
   assign mem_wdata_o = s_reg.mwdata;

   // Header stream decode, shared by the track check and search states
   always_comb begin
      hstart = disk_valid_i && disk_hdr_i && s_reg.sync && !disk_index_i
         && s_reg.hb == 3'h0;
      hend = disk_valid_i && disk_hdr_i && s_reg.sync && !disk_index_i
         && s_reg.hb == HDR_LAST;
      hcur = s_reg.hlive;
      hcur[HDR_BYTES-1] = disk_word_i[7:0];
      // Counter already holds this header's number at its last byte
      psel = hend && s_reg.seen_idx && s_reg.phys == s_reg.sect[7:0];
      trk_ok = hcur[HDR_CYL_HI] == s_reg.cyl[15:8]
         && hcur[HDR_CYL_LO] == s_reg.cyl[7:0]
         && hcur[HDR_HEAD] == s_reg.sect[15:8];
      // Larger sizes would wrap round inside the current sector buffer
      clamp = (s_reg.dsize > SBUF_WORDS) ? SBUF_WORDS : s_reg.dsize;
   end

   // Next state of the whole engine
   always_comb begin
      s_next = s_reg;
      s_next.sb_we = 1'b0;
      s_next.tbuf_we = 1'b0;
      s_next.rdat = 16'h0000;
      // Track position: index restarts the physical count
      if (disk_index_i) begin
         s_next.phys = 8'h00;
         s_next.seen_idx = 1'b1;
         s_next.sync = 1'b1;
         s_next.hb = 3'h0;
      end else if (disk_valid_i && !disk_hdr_i) begin
         s_next.sync = 1'b1;
         s_next.hb = 3'h0;
      end else if (disk_valid_i && s_reg.sync) begin
         s_next.hlive[s_reg.hb] = disk_word_i[7:0];
         s_next.hb = hend ? 3'h0 : s_reg.hb + 3'h1;
         if (hstart) begin
            s_next.phys = s_reg.phys + 8'h01;
         end
      end
      // Host register reads
      if (rd_i) begin
         if (addr_i == REG_CMD) begin
            s_next.rdat = {s_reg.dir, s_reg.trk, s_reg.any, s_reg.tgl,
               9'h000, s_reg.op};
         end else if (addr_i == REG_ADDR) begin
            s_next.rdat = s_reg.maddr;
         end else if (addr_i == REG_SECT) begin
            s_next.rdat = s_reg.sect;
         end else if (addr_i == REG_CYL) begin
            s_next.rdat = s_reg.cyl;
         end else if (addr_i == REG_DSIZE) begin
            s_next.rdat = s_reg.dsize;
         end else if (addr_i == REG_STAT) begin
            s_next.rdat = 16'h0000;
            s_next.rdat[STAT_BUSY] = s_reg.st != S_IDLE;
            s_next.rdat[STAT_CUR] = s_reg.cur;
            s_next.rdat[STAT_DONE] = s_reg.done;
            s_next.rdat[STAT_ERR] = s_reg.err;
         end
      end
      // Host writes land only while idle, so a command sees stable fields
      if (wr_i && s_reg.st == S_IDLE) begin
         if (addr_i == REG_ADDR) begin
            s_next.maddr = wr_data_i;
         end else if (addr_i == REG_SECT) begin
            s_next.sect = wr_data_i;
         end else if (addr_i == REG_CYL) begin
            s_next.cyl = wr_data_i;
         end else if (addr_i == REG_DSIZE) begin
            s_next.dsize = wr_data_i;
         end else if (addr_i == REG_CMD) begin
            s_next.op = wr_data_i[2:0];
            s_next.tgl = wr_data_i[CMD_TOGGLE_BIT];
            s_next.any = wr_data_i[CMD_ANY_BIT];
            s_next.trk = wr_data_i[CMD_TRACK_BIT];
            s_next.dir = wr_data_i[CMD_DIR_BIT];
            s_next.idx = 16'h0000;
            s_next.trkn = 2'h0;
            s_next.done = 1'b0;
            s_next.err = 1'b0;
            case (wr_data_i[2:0])
               OP_WBUF: begin
                  s_next.cnt = clamp;
                  s_next.st = S_IN_REQ;
               end
               OP_RBUF: begin
                  s_next.cnt = clamp;
                  s_next.st = S_OUT_FETCH;
               end
               OP_RHDR: begin
                  s_next.cnt = HDR_WORDS;
                  s_next.st = S_SEARCH;
               end
               OP_RPHYS: begin
                  s_next.cnt = s_reg.dsize;
                  s_next.st = wr_data_i[CMD_TRACK_BIT] ? S_TRK : S_SEARCH;
               end
               OP_REGS: begin
                  s_next.cnt = FMT_WORDS;
                  // Dump writes memory, load reads it
                  s_next.st = wr_data_i[CMD_DIR_BIT] ? S_OUT_FETCH
                     : S_IN_REQ;
               end
               default: begin
                  s_next.st = S_IDLE;
               end
            endcase
         end
      end
      // Command sequencer
      case (s_reg.st)
         S_IDLE: begin
            // Commands start from the host write above; keep its state
         end
         S_IN_REQ: begin
            if (s_reg.idx >= s_reg.cnt) begin
               s_next.st = S_FIN;
            end else begin
               s_next.mreq = 1'b1;
               s_next.mwr = 1'b0;
               s_next.maddr_o = s_reg.maddr + s_reg.idx;
               s_next.st = S_IN_WAIT;
            end
         end
         S_IN_WAIT: begin
            if (mem_ack_i) begin
               s_next.mreq = 1'b0;
               if (s_reg.op == OP_WBUF) begin
                  s_next.sb_we = 1'b1;
                  s_next.sb_addr = {s_reg.cur, s_reg.idx[7:0]};
                  s_next.sb_wd = mem_rdata_i;
               end else begin
                  // Load stores this word in formatter register idx[2:0]
                  s_next.fmt[s_reg.idx[2:0]] = mem_rdata_i;
               end
               s_next.idx = s_reg.idx + 16'h0001;
               s_next.st = S_IN_REQ;
            end
         end
         S_OUT_FETCH: begin
            if (s_reg.idx >= s_reg.cnt) begin
               s_next.st = S_FIN;
            end else begin
               s_next.sb_addr = {s_reg.cur, s_reg.idx[7:0]};
               s_next.tbuf_addr = s_reg.idx[TBUF_AW-1:0];
               s_next.st = S_OUT_REQ;
            end
         end
         S_OUT_REQ: begin
            case (s_reg.op)
               OP_RBUF: s_next.mwdata = sb_if.rdata;
               OP_RPHYS: s_next.mwdata = tbuf_if.rdata;
               OP_RHDR: s_next.mwdata = {8'h00, s_reg.hdr[s_reg.idx[2:0]]};
               default: s_next.mwdata = s_reg.fmt[s_reg.idx[2:0]];
            endcase
            s_next.mreq = 1'b1;
            s_next.mwr = 1'b1;
            s_next.maddr_o = s_reg.maddr + s_reg.idx;
            s_next.st = S_OUT_WAIT;
         end
         S_OUT_WAIT: begin
            if (mem_ack_i) begin
               s_next.mreq = 1'b0;
               s_next.mwr = 1'b0;
               s_next.idx = s_reg.idx + 16'h0001;
               s_next.st = S_OUT_FETCH;
            end
         end
         S_TRK: begin
            // Any header off the wanted cylinder or head aborts
            if (hend && !trk_ok) begin
               s_next.err = 1'b1;
               s_next.st = S_FIN;
            end else if (hend && s_reg.trkn == TRK_HDR_LAST) begin
               s_next.st = S_SEARCH;
            end else if (hend) begin
               s_next.trkn = s_reg.trkn + 2'h1;
            end
         end
         S_SEARCH: begin
            // No timeout: a missing sector keeps the engine searching
            if (s_reg.op == OP_RHDR && hend && (psel || s_reg.any)) begin
               s_next.hdr = hcur;
               s_next.idx = 16'h0000;
               s_next.st = S_OUT_FETCH;
            end else if (s_reg.op == OP_RPHYS && psel) begin
               s_next.idx = 16'h0000;
               s_next.st = S_CAP;
            end
         end
         S_CAP: begin
            // A header ends a short field; only captured words go out
            if (s_reg.idx >= s_reg.cnt || (disk_valid_i && disk_hdr_i)) begin
               s_next.cnt = s_reg.idx;
               s_next.idx = 16'h0000;
               s_next.st = S_OUT_FETCH;
            end else if (disk_valid_i) begin
               s_next.tbuf_we = 1'b1;
               s_next.tbuf_addr = s_reg.idx[TBUF_AW-1:0];
               s_next.tbuf_wd = disk_word_i;
               s_next.idx = s_reg.idx + 16'h0001;
            end
         end
         S_FIN: begin
            s_next.done = 1'b1;
            if (s_reg.tgl
               && (s_reg.op == OP_WBUF || s_reg.op == OP_RBUF)) begin
               s_next.cur = !s_reg.cur;
            end
            s_next.st = S_IDLE;
         end
         default: begin
            s_next.st = S_IDLE;
         end
      endcase
   end

   // State register; reset picks the first sector buffer
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.dsize <= DSIZE_RST;
      end else if (ce_i) begin
         s_reg <= s_next;
      end
   end

   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   a_reset_first_buf: assert property ($fell(rst_i) |-> !s_reg.cur)
      else $error("first sector buffer not current after reset");
   a_write_toggle: assert property (s_reg.st == S_FIN && ce_i
      && s_reg.tgl && s_reg.op == OP_WBUF
      |=> s_reg.cur != $past(s_reg.cur))
      else $error("toggled buffer write kept the buffer");
   a_read_toggle: assert property (s_reg.st == S_FIN && ce_i
      && s_reg.tgl && s_reg.op == OP_RBUF
      |=> s_reg.cur != $past(s_reg.cur))
      else $error("toggled buffer read kept the buffer");
   a_buf_write_sel: assert property (s_reg.sb_we |->
      s_reg.sb_addr[8] == s_reg.cur && s_reg.op == OP_WBUF)
      else $error("sector buffer written outside the current one");
   a_word_count: assert property (s_reg.st == S_IN_WAIT
      && s_reg.op == OP_WBUF |-> s_reg.idx < s_reg.cnt
      && s_reg.cnt <= SBUF_WORDS)
      else $error("buffer write past its word count");
   a_mem_read_dir: assert property (s_reg.mreq && !s_reg.mwr |->
      s_reg.op == OP_WBUF || (s_reg.op == OP_REGS && !s_reg.dir))
      else $error("memory read in a command that should write");
   a_dump_dir: assert property (s_reg.mreq && s_reg.mwr
      && s_reg.op == OP_REGS |-> s_reg.dir)
      else $error("register dump issued with load direction");
   a_hdr_six: assert property (s_reg.st == S_OUT_REQ
      && s_reg.op == OP_RHDR |-> s_reg.cnt == HDR_WORDS && s_reg.idx < 6)
      else $error("header read moves other than six words");
   a_regs_seven: assert property (s_reg.st == S_OUT_REQ
      && s_reg.op == OP_REGS |-> s_reg.cnt == FMT_WORDS && s_reg.idx < 7)
      else $error("register dump moves other than seven words");
   a_phys_match: assert property (s_reg.st == S_SEARCH && ce_i
      && s_next.st == S_CAP |-> s_reg.seen_idx
      && s_reg.phys == s_reg.sect[7:0])
      else $error("sector captured without a physical match");
   a_trk_reject: assert property (s_reg.st == S_TRK && ce_i && hend
      && !trk_ok |=> s_reg.err && s_reg.st == S_FIN ##1 s_reg.st == S_IDLE)
      else $error("track check mismatch not reported");
endmodule
`default_nettype wire

// *** tb/dcd_mem_model.sv ***
// Main memory model answering the engine's word requests
`timescale 1ns/1ns
`default_nettype none
module dcd_mem_model (
   input wire logic clock_i,
   input wire logic req_i,
   input wire logic wr_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic [3:0] dly_i,
   output logic [15:0] rdata_o,
   output logic ack_o
);
   logic [15:0] mem [0:65535];
   logic [3:0] wait_cnt;
   initial begin
      ack_o = 1'b0;
      rdata_o = 16'h0000;
      wait_cnt = 4'h0;
   end
   // One ack per request after dly_i waits; data bus churns off-ack so
   // a stale sample never looks right by luck
   always @(posedge clock_i) begin
      rdata_o <= ~rdata_o;
      if (ack_o) begin
         ack_o <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (req_i && wait_cnt >= dly_i) begin
         ack_o <= 1'b1;
         rdata_o <= mem[addr_i];
         if (wr_i)
            mem[addr_i] <= wdata_i;
      end else if (req_i) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the diagnostic command engine
`timescale 1ns/1ns
`default_nettype none
module tb
   import dcd_pkg::*;
;
   logic clock_i, rst_i, ce, wr, rd, req, mwr, ack, dix, dval, dhdr;
   logic [7:0] addr;
   logic [15:0] wdat, rdat, maddr, mwdat, mrdat, dword;
   logic [3:0] dly;
   int fail_count, n_checks, cyc;

   dcd_diag_engine dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
      .addr_i(addr), .wr_data_i(wdat), .wr_i(wr), .rd_i(rd),
      .rd_data_o(rdat), .mem_req_o(req), .mem_wr_o(mwr),
      .mem_addr_o(maddr), .mem_wdata_o(mwdat), .mem_rdata_i(mrdat),
      .mem_ack_i(ack), .disk_index_i(dix), .disk_valid_i(dval),
      .disk_hdr_i(dhdr), .disk_word_i(dword));
   dcd_mem_model mdl (.clock_i(clock_i), .req_i(req), .wr_i(mwr),
      .addr_i(maddr), .wdata_i(mwdat), .dly_i(dly), .rdata_o(mrdat),
      .ack_o(ack));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   task automatic results();
      $display("checks=%0d failures=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard, well above the longest expected run
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         results();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1 d = rdat;
   endtask

   function automatic logic [15:0] cw(input logic [2:0] op,
                                      input logic [3:0] opt);
      return {opt, 9'h000, op};
   endfunction

   task automatic start(input logic [15:0] c, input logic [15:0] a);
      reg_wr(REG_ADDR, a);
      reg_wr(REG_CMD, c);
   endtask

   // Poll until idle under a bounded count, then judge the status word
   task automatic finish(input logic [15:0] exp);
      logic [15:0] s;
      s = 16'h0001;
      for (int i = 0; i < 3000 && s[STAT_BUSY] !== 1'b0; i++)
         reg_rd(REG_STAT, s);
      chk(s, exp);
   endtask

   // Fill a memory run with a ramp and a sentinel just past its end
   task automatic fill(input logic [15:0] b, input int n,
                       input logic [15:0] v);
      for (int i = 0; i < n; i++)
         mdl.mem[b + 16'(i)] = v + 16'(i);
      mdl.mem[b + 16'(n)] = 16'hDEAD;
   endtask

   task automatic chk_mem(input logic [15:0] b, input int n,
                          input logic [15:0] v);
      for (int i = 0; i < n; i++)
         chk(mdl.mem[b + 16'(i)], v + 16'(i));
      chk(mdl.mem[b + 16'(n)], 16'hDEAD);
   endtask

   // Header byte j of sector s; junk upper byte tests zero extension
   function automatic logic [15:0] hb(input logic [7:0] cl, input int s,
                                      input int j);
      logic [7:0] t [6];
      t = '{8'h00, cl, 8'h01, 8'h40 + 8'(s), 8'hA0 + 8'(s), 8'hB0 + 8'(s)};
      return {8'hEE, t[j]};
   endfunction

   // One revolution: index, then five sectors of header plus 4 data words
   task automatic track(input logic [7:0] cl);
      @(posedge clock_i);
      dix <= 1'b1;
      @(posedge clock_i);
      dix <= 1'b0;
      for (int s = 1; s <= 5; s++) begin
         for (int j = 0; j < 10; j++) begin
            dval <= 1'b1;
            dhdr <= (j < 6);
            dword <= (j < 6) ? hb(cl, s, j) : 16'hD000 + 16'(s * 256 + j - 6);
            @(posedge clock_i);
         end
         dval <= 1'b0;
         @(posedge clock_i);
      end
   endtask

   task automatic t_reset();
      logic [15:0] v;
      reg_rd(REG_STAT, v);
      chk(v, 16'h0000);
      reg_rd(REG_DSIZE, v);
      chk(v, 16'h0100);
      reg_rd(8'h1C, v);
      chk(v, 16'h0000);
      // Read data stands one cycle, then returns to zero
      reg_rd(REG_DSIZE, v);
      @(posedge clock_i);
      #1 chk(rdat, 16'h0000);
      // A write under a low clock enable must not land
      ce <= 1'b0;
      reg_wr(REG_DSIZE, 16'h1234);
      ce <= 1'b1;
      reg_rd(REG_DSIZE, v);
      chk(v, 16'h0100);
   endtask

   task automatic t_bufs();
      fill(16'h1000, 256, 16'h1100);
      fill(16'h2000, 256, 16'h2200);
      fill(16'h3000, 256, 16'h7000);
      fill(16'h4000, 256, 16'h7000);
      fill(16'h5000, 4, 16'h7000);
      start(cw(OP_WBUF, 4'h1), 16'h1000);
      finish(16'h0006);
      dly <= 4'h3;
      start(cw(OP_WBUF, 4'h1), 16'h2000);
      finish(16'h0004);
      dly <= 4'h0;
      start(cw(OP_RBUF, 4'h1), 16'h3000);
      finish(16'h0006);
      chk_mem(16'h3000, 256, 16'h1100);
      start(cw(OP_RBUF, 4'h1), 16'h4000);
      finish(16'h0004);
      chk_mem(16'h4000, 256, 16'h2200);
      reg_wr(REG_DSIZE, 16'h0004);
      start(cw(OP_RBUF, 4'h0), 16'h5000);
      finish(16'h0004);
      chk_mem(16'h5000, 4, 16'h1100);
   endtask

   task automatic t_regs();
      // Small ramp gives the load seven distinct words for the dump to return
      fill(16'h6000, 7, 16'h0010);
      fill(16'h6100, 7, 16'h7000);
      start(cw(OP_REGS, 4'h0), 16'h6000);
      finish(16'h0004);
      start(cw(OP_REGS, 4'h8), 16'h6100);
      finish(16'h0004);
      chk_mem(16'h6100, 7, 16'h0010);
   endtask

   task automatic t_disk();
      fill(16'h7000, 6, 16'h7000);
      fill(16'h7100, 6, 16'h7000);
      fill(16'h7200, 4, 16'h7000);
      reg_wr(REG_CYL, 16'h0012);
      reg_wr(REG_SECT, 16'h0102);
      start(cw(OP_RHDR, 4'h0), 16'h7000);
      track(8'h12);
      finish(16'h0004);
      for (int j = 0; j < 6; j++)
         chk(mdl.mem[16'h7000 + 16'(j)],
            hb(8'h12, 2, j) & 16'h00FF);
      chk(mdl.mem[16'h7006], 16'hDEAD);
      reg_wr(REG_SECT, 16'h0104);
      start(cw(OP_RHDR, 4'h2), 16'h7100);
      track(8'h12);
      finish(16'h0004);
      for (int j = 0; j < 6; j++)
         chk(mdl.mem[16'h7100 + 16'(j)], hb(8'h12, 1, j) & 16'h00FF);
      start(cw(OP_RPHYS, 4'h4), 16'h7200);
      track(8'h12);
      finish(16'h0004);
      chk_mem(16'h7200, 4, 16'hD400);
      mdl.mem[16'h7300] = 16'h7000;
      reg_wr(REG_CYL, 16'h0013);
      start(cw(OP_RPHYS, 4'h4), 16'h7300);
      track(8'h12);
      finish(16'h000C);
      chk(mdl.mem[16'h7300], 16'h7000);
   endtask

   initial begin
      fail_count = 0;
      n_checks = 0;
      cyc = 0;
      rst_i = 1'b1;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdat = 16'h0000;
      dix = 1'b0;
      dval = 1'b0;
      dhdr = 1'b0;
      dword = 16'h0000;
      dly = 4'h0;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset();
      t_bufs();
      t_regs();
      t_disk();
      results();
   end
endmodule
`default_nettype wire
